// ===== rtl/ds3_sts_path_pm_counters.sv
// ds3 line and sts path performance-monitoring counters with unavailability tracking
// assumes anomaly strobes are one-cycle pulses synchronous to clk and defects are levels
`timescale 1ns/1ps

// ------------------------------------------------------------
// unavailability tracker, one per path end
// ------------------------------------------------------------
module unavail_tracker #(
  parameter int CNT_W = pm_counters_pkg::CNT_W
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic second_tick,
  input wire logic severe_second,
  output logic [CNT_W-1:0] unavail_seconds,
  output logic unavailable
);

  typedef enum logic [1:0] {
    ST_AVAIL = 2'b01,
    ST_UNAVAIL = 2'b10
  } uas_state_t;

  typedef struct packed {
    uas_state_t state;
    pm_counters_pkg::run_t run;
    logic [CNT_W-1:0] uas;
  } tracker_t;

  tracker_t s_q;
  tracker_t s_d;

  // run counts consecutive severe seconds while available, clean ones while unavailable
  always_comb begin
    s_d = s_q;
    if (second_tick) begin
      case (s_q.state)
        ST_AVAIL: begin
          if (severe_second) begin
            if (s_q.run == pm_counters_pkg::run_t'(pm_counters_pkg::UAS_RUN - 1)) begin
              // the whole run of severe seconds becomes unavailable at once
              s_d.state = ST_UNAVAIL;
              s_d.uas = s_q.uas + CNT_W'(pm_counters_pkg::UAS_RUN);
              s_d.run = '0;
            end else begin
              s_d.run = s_q.run + pm_counters_pkg::run_t'(1);
            end
          end else begin
            s_d.run = '0;
          end
        end
        ST_UNAVAIL: begin
          if (!severe_second) begin
            if (s_q.run == pm_counters_pkg::run_t'(pm_counters_pkg::UAS_RUN - 1)) begin
              // clean seconds of a full run are never added, so leaving credits them as available
              s_d.state = ST_AVAIL;
              s_d.run = '0;
            end else begin
              s_d.run = s_q.run + pm_counters_pkg::run_t'(1);
            end
          end else begin
            // a short clean run stays unavailable; charge it plus this second
            s_d.uas = s_q.uas + CNT_W'(s_q.run) + CNT_W'(1);
            s_d.run = '0;
          end
        end
        default: begin
          s_d.state = ST_AVAIL;
          s_d.run = '0;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (reset) begin
      s_q.state <= ST_AVAIL;
      s_q.run <= '0;
      s_q.uas <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign unavail_seconds = s_q.uas;
  assign unavailable = s_q.state[1]; // one-hot bit of ST_UNAVAIL, straight from the flop

endmodule : unavail_tracker

// ------------------------------------------------------------
// top: line and path accumulators
// ------------------------------------------------------------
module ds3_sts_path_pm_counters #(
  parameter int CNT_W = pm_counters_pkg::CNT_W
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic second_tick,
  input wire logic bipolar_violation,
  input wire logic excess_zeros,
  input wire logic signal_loss_defect,
  input wire logic path_bip_valid,
  input wire logic [pm_counters_pkg::BIP_W-1:0] path_bip_errors,
  input wire logic far_bip_valid,
  input wire logic [pm_counters_pkg::BIP_W-1:0] far_bip_errors,
  input wire logic path_alarm_indication,
  input wire logic path_pointer_loss,
  input wire logic path_unequipped,
  input wire logic path_trace_mismatch,
  input wire logic far_failure_declared,
  input wire logic path_remote_defect_indication,
  input wire logic rdi_supported,
  output logic [CNT_W-1:0] line_coding_violations,
  output logic [CNT_W-1:0] line_errored_seconds,
  output logic [CNT_W-1:0] line_severe_errored_seconds,
  output logic [CNT_W-1:0] line_loss_seconds,
  output logic [CNT_W-1:0] path_coding_violations,
  output logic [CNT_W-1:0] path_errored_seconds,
  output logic [CNT_W-1:0] path_severe_errored_seconds,
  output logic [CNT_W-1:0] path_failure_count,
  output logic [CNT_W-1:0] path_unavailable_seconds,
  output logic path_unavailable,
  output logic [CNT_W-1:0] far_path_coding_violations,
  output logic [CNT_W-1:0] far_path_errored_seconds,
  output logic [CNT_W-1:0] far_path_severe_errored_seconds,
  output logic [CNT_W-1:0] far_path_failure_count,
  output logic [CNT_W-1:0] far_path_unavailable_seconds,
  output logic far_path_unavailable
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [CNT_W-1:0] line_cv;
    logic [CNT_W-1:0] line_es;
    logic [CNT_W-1:0] line_ses;
    logic [CNT_W-1:0] line_loss;
    logic [CNT_W-1:0] near_cv;
    logic [CNT_W-1:0] near_es;
    logic [CNT_W-1:0] near_ses;
    logic [CNT_W-1:0] near_fc;
    logic [CNT_W-1:0] far_cv;
    logic [CNT_W-1:0] far_es;
    logic [CNT_W-1:0] far_ses;
    logic [CNT_W-1:0] far_fc;
    pm_counters_pkg::sec_acc_t line_acc;
    pm_counters_pkg::sec_acc_t near_acc;
    pm_counters_pkg::sec_acc_t far_acc;
    logic los_seen;
    logic defect_seen;
    logic near_fail_q;
    logic far_fail_q;
  } pm_state_t;

  pm_state_t s_q;
  pm_state_t s_d;

  // ------------------------------------------------------------
  // per-cycle increments
  // ------------------------------------------------------------
  logic [1:0] line_inc;
  logic [pm_counters_pkg::BIP_W-1:0] near_inc;
  logic [pm_counters_pkg::BIP_W-1:0] far_inc;

  // frame counts above eight are clipped; the processor can report up to 15
  function automatic logic [pm_counters_pkg::BIP_W-1:0] clip_bip(
    input logic valid,
    input logic [pm_counters_pkg::BIP_W-1:0] errs
  );
    logic [pm_counters_pkg::BIP_W-1:0] r;
    r = '0;
    if (valid) begin
      r = (errs > pm_counters_pkg::MAX_BIP_PER_FRAME) ? pm_counters_pkg::MAX_BIP_PER_FRAME : errs;
    end
    return r;
  endfunction : clip_bip

  // saturating add keeps the second accumulators from wrapping under a storm
  function automatic pm_counters_pkg::sec_acc_t sat_add(
    input pm_counters_pkg::sec_acc_t acc,
    input logic [pm_counters_pkg::BIP_W-1:0] inc
  );
    pm_counters_pkg::sec_acc_t r;
    r = acc;
    if (acc < pm_counters_pkg::SEC_ACC_MAX) begin
      r = acc + pm_counters_pkg::sec_acc_t'(inc);
    end
    return r;
  endfunction : sat_add

  assign line_inc = {1'b0, bipolar_violation} + {1'b0, excess_zeros};
  assign near_inc = clip_bip(path_bip_valid, path_bip_errors);
  assign far_inc = clip_bip(far_bip_valid, far_bip_errors);

  // ------------------------------------------------------------
  // second-so-far view, including this cycle's events
  // ------------------------------------------------------------
  pm_counters_pkg::sec_acc_t line_acc_now;
  pm_counters_pkg::sec_acc_t near_acc_now;
  pm_counters_pkg::sec_acc_t far_acc_now;
  logic los_now;
  logic defect_now;
  logic near_fail_now;
  logic far_fail_now;

  // events coinciding with the tick fold into the closing second, so none are lost
  assign line_acc_now = sat_add(s_q.line_acc, {2'b00, line_inc});
  assign near_acc_now = sat_add(s_q.near_acc, near_inc);
  assign far_acc_now = sat_add(s_q.far_acc, far_inc);
  assign los_now = s_q.los_seen | signal_loss_defect;
  assign defect_now = s_q.defect_seen | path_alarm_indication | path_pointer_loss;

  // failure conditions as levels; an event is the rise of the combined level
  assign near_fail_now = path_alarm_indication | path_pointer_loss | path_unequipped | path_trace_mismatch;
  assign far_fail_now = far_failure_declared | (rdi_supported & path_remote_defect_indication);

  // ------------------------------------------------------------
  // second classification
  // ------------------------------------------------------------
  logic line_es_sec;
  logic line_ses_sec;
  logic near_es_sec;
  logic near_ses_sec;
  logic far_es_sec;
  logic far_ses_sec;

  assign line_es_sec = (line_acc_now != '0) | los_now;
  assign line_ses_sec = (line_acc_now >= pm_counters_pkg::LINE_SES_THRESH) | los_now;
  assign near_es_sec = (near_acc_now != '0) | defect_now;
  assign near_ses_sec = (near_acc_now >= pm_counters_pkg::PATH_SES_THRESH) | defect_now;
  assign far_es_sec = (far_acc_now != '0) | defect_now;
  assign far_ses_sec = (far_acc_now >= pm_counters_pkg::PATH_SES_THRESH) | defect_now;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // running violation totals, every cycle
    s_d.line_cv = s_q.line_cv + CNT_W'(line_inc);
    s_d.near_cv = s_q.near_cv + CNT_W'(near_inc);
    s_d.far_cv = s_q.far_cv + CNT_W'(far_inc);
    // failure events on the rising edge of the combined failure level
    s_d.near_fail_q = near_fail_now;
    s_d.far_fail_q = far_fail_now;
    if (near_fail_now && !s_q.near_fail_q) begin
      s_d.near_fc = s_q.near_fc + CNT_W'(1);
    end
    if (far_fail_now && !s_q.far_fail_q) begin
      s_d.far_fc = s_q.far_fc + CNT_W'(1);
    end
    if (second_tick) begin
      // close the second: update interval counters, then clear accumulators
      if (line_es_sec) begin
        s_d.line_es = s_q.line_es + CNT_W'(1);
      end
      if (line_ses_sec) begin
        s_d.line_ses = s_q.line_ses + CNT_W'(1);
      end
      if (los_now) begin
        s_d.line_loss = s_q.line_loss + CNT_W'(1);
      end
      if (near_es_sec) begin
        s_d.near_es = s_q.near_es + CNT_W'(1);
      end
      if (near_ses_sec) begin
        s_d.near_ses = s_q.near_ses + CNT_W'(1);
      end
      if (far_es_sec) begin
        s_d.far_es = s_q.far_es + CNT_W'(1);
      end
      if (far_ses_sec) begin
        s_d.far_ses = s_q.far_ses + CNT_W'(1);
      end
      s_d.line_acc = '0;
      s_d.near_acc = '0;
      s_d.far_acc = '0;
      s_d.los_seen = 1'b0;
      s_d.defect_seen = 1'b0;
    end else begin
      s_d.line_acc = line_acc_now;
      s_d.near_acc = near_acc_now;
      s_d.far_acc = far_acc_now;
      s_d.los_seen = los_now;
      s_d.defect_seen = defect_now;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // unavailability, near and far end
  // ------------------------------------------------------------
  unavail_tracker #(
    .CNT_W(CNT_W)
  ) near_uas (
    .clk(clk),
    .reset(reset),
    .second_tick(second_tick),
    .severe_second(near_ses_sec),
    .unavail_seconds(path_unavailable_seconds),
    .unavailable(path_unavailable)
  );

  unavail_tracker #(
    .CNT_W(CNT_W)
  ) far_uas (
    .clk(clk),
    .reset(reset),
    .second_tick(second_tick),
    .severe_second(far_ses_sec),
    .unavail_seconds(far_path_unavailable_seconds),
    .unavailable(far_path_unavailable)
  );

  // ------------------------------------------------------------
  // outputs, all straight from the state register
  // ------------------------------------------------------------
  assign line_coding_violations = s_q.line_cv;
  assign line_errored_seconds = s_q.line_es;
  assign line_severe_errored_seconds = s_q.line_ses;
  assign line_loss_seconds = s_q.line_loss;
  assign path_coding_violations = s_q.near_cv;
  assign path_errored_seconds = s_q.near_es;
  assign path_severe_errored_seconds = s_q.near_ses;
  assign path_failure_count = s_q.near_fc;
  assign far_path_coding_violations = s_q.far_cv;
  assign far_path_errored_seconds = s_q.far_es;
  assign far_path_severe_errored_seconds = s_q.far_ses;
  assign far_path_failure_count = s_q.far_fc;

endmodule : ds3_sts_path_pm_counters

// ===== rtl/pm_counters_pkg.sv
// constants, types and thresholds shared by the performance-monitoring accumulator
// assumes a one-second tick from elsewhere and per-frame error counts from the path processor
package pm_counters_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int CNT_W = 32;
  localparam int BIP_W = 4;
  localparam int SEC_ACC_W = 16;
  localparam int RUN_W = 4;

  // ------------------------------------------------------------
  // thresholds and limits
  // ------------------------------------------------------------
  localparam logic [SEC_ACC_W-1:0] LINE_SES_THRESH = 16'h002c; // 44 anomalies
  localparam logic [SEC_ACC_W-1:0] PATH_SES_THRESH = 16'h0960; // 2400 parity errors
  localparam logic [SEC_ACC_W-1:0] SEC_ACC_MAX = 16'hfff0;    // saturation point, far above both thresholds
  localparam logic [BIP_W-1:0] MAX_BIP_PER_FRAME = 4'h8;
  localparam int UAS_RUN = 10;                                 // seconds to enter or leave unavailability

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef logic [RUN_W-1:0] run_t;
  typedef logic [SEC_ACC_W-1:0] sec_acc_t;

endpackage : pm_counters_pkg

// ===== test/frame_src.sv
// path overhead processor model: one parity count per frame strobe
// assumes the bench holds a go line high for one cycle per frame
`timescale 1ns/1ps
module frame_src (
  input wire logic clk,
  input wire logic near_go,
  input wire logic [3:0] near_n,
  input wire logic far_go,
  input wire logic [3:0] far_n,
  output logic path_bip_valid,
  output logic [3:0] path_bip_errors,
  output logic far_bip_valid,
  output logic [3:0] far_bip_errors
);
  // ------------------------------------------------------------
  // frames
  // ------------------------------------------------------------
  // counts are inverted between strobes so a stale count never looks valid
  always @(posedge clk) begin
    path_bip_valid <= near_go;
    path_bip_errors <= near_go ? near_n : ~near_n;
    far_bip_valid <= far_go;
    far_bip_errors <= far_go ? far_n : ~far_n;
  end
endmodule : frame_src

// ===== test/pm_checker.sv
// checker: pm counter outputs tied to their causes at the inputs
// assumes binding into ds3_sts_path_pm_counters, inputs low during reset
`timescale 1ns/1ps
module pm_checker #(
  parameter int CNT_W = 32
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic second_tick,
  input wire logic bipolar_violation,
  input wire logic excess_zeros,
  input wire logic signal_loss_defect,
  input wire logic path_bip_valid,
  input wire logic [pm_counters_pkg::BIP_W-1:0] path_bip_errors,
  input wire logic path_alarm_indication,
  input wire logic path_pointer_loss,
  input wire logic path_unequipped,
  input wire logic path_trace_mismatch,
  input wire logic far_failure_declared,
  input wire logic path_remote_defect_indication,
  input wire logic rdi_supported,
  input wire logic [CNT_W-1:0] line_coding_violations,
  input wire logic [CNT_W-1:0] line_errored_seconds,
  input wire logic [CNT_W-1:0] line_severe_errored_seconds,
  input wire logic [CNT_W-1:0] path_coding_violations,
  input wire logic [CNT_W-1:0] path_errored_seconds,
  input wire logic [CNT_W-1:0] path_failure_count,
  input wire logic [CNT_W-1:0] far_path_errored_seconds,
  input wire logic [CNT_W-1:0] far_path_failure_count,
  input wire logic path_unavailable
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // causes merged per end: an event is only the rise of the merge
  wire logic near_fail = path_alarm_indication | path_pointer_loss | path_unequipped | path_trace_mismatch;
  wire logic far_fail = far_failure_declared | (rdi_supported & path_remote_defect_indication);
  wire logic [3:0] clip = (path_bip_errors > 4'h8) ? 4'h8 : path_bip_errors;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_loss_close;
    second_tick && signal_loss_defect;
  endsequence
  sequence s_defect_close;
    second_tick && path_alarm_indication;
  endsequence
  sequence s_near_onset;
    $rose(near_fail);
  endsequence
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_line_viol_sum: assert property (
    line_coding_violations == $past(line_coding_violations) + CNT_W'($past(bipolar_violation))
    + CNT_W'($past(excess_zeros))) else $error("line violation count off");
  a_path_parity_sum: assert property (
    path_coding_violations == $past(path_coding_violations)
    + ($past(path_bip_valid) ? CNT_W'($past(clip)) : '0)) else $error("path parity count off");
  a_errsec_on_tick: assert property (
    $changed(line_errored_seconds) |-> $past(second_tick)) else $error("errored second off tick");
  a_loss_severe: assert property (
    s_loss_close |=> line_severe_errored_seconds == $past(line_severe_errored_seconds) + 1)
    else $error("signal loss second not severe");
  a_near_defect_es: assert property (
    s_defect_close |=> path_errored_seconds == $past(path_errored_seconds) + 1)
    else $error("near defect second not errored");
  a_far_defect_es: assert property (
    s_defect_close |=> far_path_errored_seconds == $past(far_path_errored_seconds) + 1)
    else $error("far defect second not errored");
  a_near_fail_rise: assert property (
    s_near_onset |=> path_failure_count == $past(path_failure_count) + 1) else $error("near failure missed");
  a_near_fail_hold: assert property (
    !$rose(near_fail) |=> $stable(path_failure_count)) else $error("near failure counted twice");
  a_far_fail_rise: assert property (
    $rose(far_fail) |=> far_path_failure_count == $past(far_path_failure_count) + 1)
    else $error("far failure missed");
  a_unavail_tick: assert property (
    $changed(path_unavailable) |-> $past(second_tick)) else $error("unavailable changed off tick");
endmodule : pm_checker

bind ds3_sts_path_pm_counters pm_checker #(.CNT_W(CNT_W)) chk_u (.*);

// ===== test/tb_top.sv
// testbench: line anomalies, frame parity, defects and failures into the pm counters
// assumes the checker binds itself and frame_src stands in for the path processor
`timescale 1ns/1ps
module tb_top;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic second_tick = 1'b0, bipolar_violation = 1'b0, excess_zeros = 1'b0, signal_loss_defect = 1'b0;
  logic far_failure_declared = 1'b0, path_remote_defect_indication = 1'b0, rdi_supported = 1'b0;
  logic near_go = 1'b0, far_go = 1'b0;
  logic [3:0] near_n = 4'h0, far_n = 4'h0, fail_src = 4'h0;
  logic path_bip_valid, far_bip_valid, path_unavailable, far_path_unavailable;
  logic [3:0] path_bip_errors, far_bip_errors;
  logic [31:0] line_coding_violations, line_errored_seconds, line_severe_errored_seconds, line_loss_seconds;
  logic [31:0] path_coding_violations, path_errored_seconds, path_severe_errored_seconds, path_failure_count;
  logic [31:0] path_unavailable_seconds, far_path_coding_violations, far_path_errored_seconds;
  logic [31:0] far_path_severe_errored_seconds, far_path_failure_count, far_path_unavailable_seconds;
  wire logic path_alarm_indication = fail_src[0];
  wire logic path_pointer_loss = fail_src[1];
  wire logic path_unequipped = fail_src[2];
  wire logic path_trace_mismatch = fail_src[3];
  int num_errors = 0;
  int compares = 0;
  // 10 MHz clock
  always #50 clk = ~clk;
  ds3_sts_path_pm_counters dut_u (.*);
  frame_src src_u (.*);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : check
  // signal loss drops with the tick so it marks only the closing second
  task automatic sec;
    @(posedge clk);
    second_tick <= 1'b1;
    @(posedge clk);
    second_tick <= 1'b0;
    signal_loss_defect <= 1'b0;
    @(posedge clk);
    #1;
  endtask : sec
  task automatic unavail(input logic up, input logic [31:0] n);
    check({31'h0, path_unavailable}, {31'h0, up});
    check(path_unavailable_seconds, n);
    check({31'h0, far_path_unavailable}, {31'h0, up});
    check(far_path_unavailable_seconds, n);
  endtask : unavail
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  // 44 anomalies, then 43 to show the accumulator cleared, then a loss second
  task automatic line_case;
    @(posedge clk);
    bipolar_violation <= 1'b1;
    excess_zeros <= 1'b1;
    @(posedge clk);
    excess_zeros <= 1'b0;
    repeat (42) @(posedge clk);
    bipolar_violation <= 1'b0;
    sec;
    check(line_coding_violations, 32'h2c);
    check(line_severe_errored_seconds, 32'h1);
    @(posedge clk);
    bipolar_violation <= 1'b1;
    repeat (43) @(posedge clk);
    bipolar_violation <= 1'b0;
    sec;
    check(line_errored_seconds, 32'h2);
    check(line_severe_errored_seconds, 32'h1);
    @(posedge clk);
    signal_loss_defect <= 1'b1;
    sec;
    check(line_loss_seconds, 32'h1);
    check(line_severe_errored_seconds, 32'h2);
    sec;
    check(line_errored_seconds, 32'h3);
  endtask : line_case
  // 300 frames: near lands on exactly 2400 through clipping (2407 unclipped), far stops at 2399
  task automatic path_case;
    @(posedge clk);
    {near_go, far_go, near_n, far_n} <= {2'b11, 4'h8, 4'h8};
    repeat (299) @(posedge clk);
    {near_n, far_n} <= {4'hf, 4'h7};
    @(posedge clk);
    {near_go, far_go} <= 2'b00;
    sec;
    check(path_coding_violations, 32'h960);
    check(path_severe_errored_seconds, 32'h1);
    check(far_path_coding_violations, 32'h95f);
    check(far_path_errored_seconds, 32'h1);
    check(far_path_severe_errored_seconds, 32'h0);
    @(posedge clk);
    {near_go, near_n, far_n} <= {1'b1, 4'h1, 4'h5};
    @(posedge clk);
    near_go <= 1'b0;
    sec;
    check(path_errored_seconds, 32'h2);
    check(path_severe_errored_seconds, 32'h1);
    check(far_path_errored_seconds, 32'h1);
  endtask : path_case
  // each cause opens one event; overlapping causes add none
  task automatic fail_case;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      fail_src <= 4'h1 << i;
      @(posedge clk);
      fail_src <= 4'hf;
      @(posedge clk);
      fail_src <= 4'h0;
      @(posedge clk);
      #1;
      check(path_failure_count, 32'(i + 1));
    end
    @(posedge clk);
    {far_failure_declared, path_remote_defect_indication} <= 2'b11;
    @(posedge clk);
    far_failure_declared <= 1'b0;
    @(posedge clk);
    rdi_supported <= 1'b1;
    #1;
    check(far_path_failure_count, 32'h1);
    repeat (2) @(posedge clk);
    #1;
    check(far_path_failure_count, 32'h2);
    sec;
    check(path_severe_errored_seconds, 32'h2);
    check(far_path_severe_errored_seconds, 32'h1);
  endtask : fail_case
  // a level dropped after a second opens still marks that second severe
  task automatic uas_case;
    sec;
    @(posedge clk);
    fail_src <= 4'h1;
    repeat (8) sec;
    @(posedge clk);
    fail_src <= 4'h0;
    repeat (2) sec;
    unavail(1'b0, 32'h0);
    @(posedge clk);
    fail_src <= 4'h1;
    repeat (10) sec;
    unavail(1'b1, 32'ha);
    @(posedge clk);
    fail_src <= 4'h0;
    repeat (3) sec;
    @(posedge clk);
    fail_src <= 4'h1;
    sec;
    unavail(1'b1, 32'he);
    @(posedge clk);
    fail_src <= 4'h0;
    repeat (10) sec;
    unavail(1'b1, 32'hf);
    sec;
    unavail(1'b0, 32'hf);
  endtask : uas_case
  // ------------------------------------------------------------
  // run control
  // ------------------------------------------------------------
  task automatic results;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    line_case;
    path_case;
    fail_case;
    uas_case;
    results;
  end
  // cuts a hang short
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    results;
  end
endmodule : tb_top
